// file: logic/chg_regs_pkg.sv
// Shared constants and types for the charger status and control register bank
package chg_regs_pkg;
  // Register offsets on the serial bus
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h01;
  localparam logic [7:0] OFS_EVENT_FLAGS  = 8'h02;
  localparam logic [7:0] OFS_VBAT_SET     = 8'h03;
  localparam logic [7:0] OFS_ICHG_SET     = 8'h04;
  localparam logic [7:0] OFS_CTRL_FIRST   = 8'h05;
  localparam logic [7:0] OFS_CTRL_SECOND  = 8'h06;
  // Reset values
  localparam logic [7:0] RST_VBAT_SET     = 8'h46;
  localparam logic [7:0] RST_ICHG_SET     = 8'h05;
  localparam logic [7:0] RST_CTRL_FIRST   = 8'h2C;
  localparam logic [7:0] RST_CTRL_SECOND  = 8'h56;
  // Fault status bit positions
  localparam int BIT_OVP_LIVE   = 7;
  localparam int BIT_BUVLO_LIVE = 6;
  localparam int BIT_ZONE_HI    = 4;
  localparam int BIT_ZONE_LO    = 3;
  localparam int BIT_TMR_FLAG   = 2;
  localparam int BIT_FIRST_WAKE = 1;
  localparam int BIT_LATER_WAKE = 0;
  // Event flag bit positions, also indices 0..7 of the flag cell array
  localparam int EV_THERM_FAULT = 7;
  localparam int EV_ILIM        = 6;
  localparam int EV_POWER_PATH  = 5;
  localparam int EV_VIN_REG     = 4;
  localparam int EV_HEAT_LIM    = 3;
  localparam int EV_OVP         = 2;
  localparam int EV_BUVLO       = 1;
  localparam int EV_BAT_OCP     = 0;
  // Flag cell indices of the status flags
  localparam int FC_WAKE2 = 8;
  localparam int FC_WAKE1 = 9;
  localparam int FC_TMR   = 10;
  localparam int FC_COUNT = 11;
  // Control field positions
  localparam int BIT_CHG_OFF  = 7;
  localparam int BIT_PRE_SEL  = 6;
  localparam int BIT_TERM_LO  = 4;
  localparam int BIT_VFLR_LO  = 2;
  localparam int BIT_THERM_LO = 0;
  // Analog set-point scaling
  localparam logic [12:0] VBAT_BASE_MV  = 13'h0DAC; // 3500 mV
  localparam logic [12:0] VBAT_STEP_MV  = 13'h000A; // 10 mV
  localparam logic [6:0]  VBAT_CODE_MAX = 7'h73;    // 115 gives 4650 mV
  localparam logic [6:0]  ICHG_LOW_MAX  = 7'h1E;    // Codes up to 30 give up to 35 mA
  localparam logic [10:0] ICHG_LOW_OFS  = 11'h005;  // 5 mA
  localparam logic [10:0] ICHG_HI_BASE  = 11'h028;  // 40 mA
  localparam logic [6:0]  ICHG_HI_CODE  = 7'h1F;    // 31
  localparam logic [10:0] ICHG_STEP_MA  = 11'h00A;  // 10 mA
  localparam logic [4:0]  TERM_PCT_LO   = 5'h05;
  localparam logic [4:0]  TERM_PCT_MID  = 5'h0A;
  localparam logic [4:0]  TERM_PCT_HI   = 5'h14;
  localparam logic [12:0] VFLR_LO_MV    = 13'h1068; // 4200 mV
  localparam logic [12:0] VFLR_MID_MV   = 13'h1194; // 4500 mV
  localparam logic [12:0] VFLR_HI_MV    = 13'h125C; // 4700 mV
  localparam logic [6:0]  THERM_LIM_C   = 7'h64;    // 100 C
  localparam logic [1:0]  SEL_OFF       = 2'h3;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  // Serial bus state machine
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_ACK  = 4'b0010,
    ST_PTR       = 4'b0011,
    ST_PTR_ACK   = 4'b0100,
    ST_WDATA     = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA     = 4'b0111,
    ST_RACK      = 4'b1000
  } bus_state_e;
endpackage

// file: logic/rc_flag.sv
// Sticky flag cell where a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module rc_flag (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_set,
  input  wire logic i_clear,
  output var  logic o_flag
);
  // Set has priority so an event coinciding with a read is never lost
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= i_set | (o_flag & ~i_clear);
    end
  end
endmodule
`default_nettype wire

// file: logic/i2c_line_sense.sv
// Clock and data line sampler with edge, start and stop detection
`timescale 1ns/1ps
`default_nettype none
module i2c_line_sense (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var  logic o_sda,
  output var  logic o_scl_rise,
  output var  logic o_scl_fall,
  output var  logic o_start,
  output var  logic o_stop
);
  logic scl_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  // Lines idle high, so reset to high avoids a false start
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      scl_reg      <= 1'b1;
      scl_prev_reg <= 1'b1;
      o_sda        <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_reg      <= i_scl;
      scl_prev_reg <= scl_reg;
      o_sda        <= i_sda;
      sda_prev_reg <= o_sda;
    end
  end

  // Data moving while the clock is high marks frame boundaries
  always_comb begin
    o_scl_rise = scl_reg & ~scl_prev_reg;
    o_scl_fall = ~scl_reg & scl_prev_reg;
    o_start    = scl_reg & scl_prev_reg & sda_prev_reg & ~o_sda;
    o_stop     = scl_reg & scl_prev_reg & ~sda_prev_reg & o_sda;
  end
endmodule
`default_nettype wire

// file: logic/charger_status_and_control_regs.sv
// Charger status, event flag and charge control registers behind a serial bus target
`timescale 1ns/1ps
`default_nettype none
module charger_status_and_control_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h35 // Target address, value arbitrary
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda_in,
  output var  logic        o_sda_out,
  output var  logic        o_sda_oe_n,
  input  wire logic        i_input_overvoltage,
  input  wire logic        i_battery_lockout,
  input  wire logic [1:0]  i_thermistor_zone,
  input  wire logic        i_charge_timer_expired,
  input  wire logic        i_charge_enable,
  input  wire logic        i_first_wake,
  input  wire logic        i_second_wake,
  input  wire logic        i_thermistor_fault,
  input  wire logic        i_input_current_limit,
  input  wire logic        i_power_path_regulation,
  input  wire logic        i_input_voltage_regulation,
  input  wire logic        i_thermal_regulation,
  input  wire logic        i_battery_overcurrent,
  output var  logic        o_charging_off,
  output var  logic [12:0] o_battery_voltage_mv,
  output var  logic [10:0] o_fast_charge_ma,
  output var  logic [4:0]  o_termination_pct,
  output var  logic [5:0]  o_precharge_pct,
  output var  logic [12:0] o_input_floor_mv,
  output var  logic [6:0]  o_thermal_limit_c,
  output var  logic [7:0]  o_ctrl_second
);
  import chg_regs_pkg::*;

  logic               sda_s;
  logic               scl_rise;
  logic               scl_fall;
  logic               bus_start;
  logic               bus_stop;
  bus_state_e         state_reg;
  logic [3:0]         bit_cnt_reg;
  logic [7:0]         shift_in_reg;
  logic [7:0]         shift_out_reg;
  logic [7:0]         ptr_reg;
  logic               rw_reg;
  logic               nack_reg;
  logic               byte_done;
  logic               wr_fire;
  logic               rd_fire;
  logic [7:0]         rd_data;
  logic [7:0]         status_live_reg;
  logic [7:0]         vbat_reg;
  logic [7:0]         ichg_reg;
  logic [7:0]         ctrl0_reg;
  logic               en_prev_reg;
  logic               tmr_arm_reg;
  logic [FC_COUNT-1:0] flag_set;
  logic [FC_COUNT-1:0] flag_clr;
  logic [FC_COUNT-1:0] flag_q;
  logic [6:0]         battery_voltage_code;
  logic [6:0]         fast_charge_code;
  logic               precharge_ratio_select;
  logic [1:0]         termination_select;
  logic [1:0]         input_voltage_floor_select;
  logic [1:0]         thermal_threshold_select;
  logic [4:0]         term_pct;

  i2c_line_sense u_sense (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda_in),
    .o_sda      (sda_s),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (bus_start),
    .o_stop     (bus_stop)
  );

  // Byte boundaries and register access strobes
  assign byte_done = scl_fall && (bit_cnt_reg == BYTE_BITS);
  assign wr_fire   = (state_reg == ST_WDATA) && byte_done;
  assign rd_fire   = scl_fall && (((state_reg == ST_ADDR_ACK) && rw_reg) ||
                                  ((state_reg == ST_RACK) && !nack_reg));

  // Bus state, bit counting and data line drive
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      rw_reg        <= 1'b0;
      nack_reg      <= 1'b0;
      o_sda_oe_n    <= 1'b1;
      shift_out_reg <= 8'h00;
    end else if (bus_start || bus_stop) begin
      state_reg   <= bus_start ? ST_ADDR : ST_IDLE;
      bit_cnt_reg <= 4'h0;
      o_sda_oe_n  <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          o_sda_oe_n <= 1'b1;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= 4'h0;
            // A foreign address is ignored until the next start
            if (state_reg == ST_ADDR && shift_in_reg[7:1] != DEV_ADDR) begin
              state_reg <= ST_IDLE;
            end else begin
              o_sda_oe_n <= 1'b0;
              rw_reg     <= (state_reg == ST_ADDR) ? shift_in_reg[0] : rw_reg;
              state_reg  <= (state_reg == ST_ADDR) ? ST_ADDR_ACK :
                            (state_reg == ST_PTR) ? ST_PTR_ACK : ST_WDATA_ACK;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            o_sda_oe_n <= 1'b1;
            state_reg  <= ST_WDATA;
          end
        end
        ST_ADDR_ACK, ST_RACK: begin
          if (scl_rise) begin
            nack_reg <= sda_s;
          end else if (rd_fire) begin
            // Open drain: a one is sent by releasing the line
            o_sda_oe_n    <= rd_data[7];
            shift_out_reg <= {rd_data[6:0], 1'b0};
            bit_cnt_reg   <= 4'h1;
            state_reg     <= ST_RDATA;
          end else if (scl_fall) begin
            o_sda_oe_n <= 1'b1;
            state_reg  <= (state_reg == ST_ADDR_ACK) ? ST_PTR : ST_IDLE;
          end
        end
        ST_RDATA: begin
          if (scl_fall && bit_cnt_reg != BYTE_BITS) begin
            o_sda_oe_n    <= shift_out_reg[7];
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            bit_cnt_reg   <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            o_sda_oe_n <= 1'b1;
            nack_reg   <= 1'b0;
            state_reg  <= ST_RACK;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Incoming bits, sampled while the clock is high
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      shift_in_reg <= 8'h00;
    end else if (scl_rise) begin
      shift_in_reg <= {shift_in_reg[6:0], sda_s};
    end
  end

  // Data level stays low; the enable alone shapes the open-drain line
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sda_out <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
    end
  end

  // Register pointer with auto increment after every data byte
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ptr_reg <= 8'h00;
    end else if (state_reg == ST_PTR && byte_done) begin
      ptr_reg <= shift_in_reg;
    end else if (wr_fire || rd_fire) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // Live status bits follow the analog side each cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      status_live_reg <= 8'h00;
    end else begin
      status_live_reg                          <= 8'h00;
      status_live_reg[BIT_OVP_LIVE]            <= i_input_overvoltage;
      status_live_reg[BIT_BUVLO_LIVE]          <= i_battery_lockout;
      status_live_reg[BIT_ZONE_HI:BIT_ZONE_LO] <= i_thermistor_zone;
    end
  end

  // Timer flag clears on read only once the charge enable has toggled
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      en_prev_reg <= 1'b0;
      tmr_arm_reg <= 1'b0;
    end else begin
      en_prev_reg <= i_charge_enable;
      tmr_arm_reg <= flag_q[FC_TMR] & (tmr_arm_reg | (i_charge_enable ^ en_prev_reg));
    end
  end

  // Flag sources; conditions that persist keep setting their flag
  always_comb begin
    flag_set                = '0;
    flag_set[EV_THERM_FAULT] = i_thermistor_fault;
    flag_set[EV_ILIM]       = i_input_current_limit;
    flag_set[EV_POWER_PATH] = i_power_path_regulation;
    flag_set[EV_VIN_REG]    = i_input_voltage_regulation;
    flag_set[EV_HEAT_LIM]   = i_thermal_regulation;
    flag_set[EV_OVP]        = i_input_overvoltage;
    flag_set[EV_BUVLO]      = i_battery_lockout;
    flag_set[EV_BAT_OCP]    = i_battery_overcurrent;
    flag_set[FC_WAKE2]      = i_second_wake;
    flag_set[FC_WAKE1]      = i_first_wake;
    flag_set[FC_TMR]        = i_charge_timer_expired;
    flag_clr                = '0;
    flag_clr[EV_THERM_FAULT:EV_BAT_OCP] = {8{rd_fire && ptr_reg == OFS_EVENT_FLAGS}};
    flag_clr[FC_WAKE2]      = rd_fire && ptr_reg == OFS_FAULT_STATUS;
    flag_clr[FC_WAKE1]      = rd_fire && ptr_reg == OFS_FAULT_STATUS;
    flag_clr[FC_TMR]        = rd_fire && ptr_reg == OFS_FAULT_STATUS && tmr_arm_reg;
  end

  for (genvar g = 0; g < FC_COUNT; g++) begin : g_flag
    rc_flag u_flag (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_set   (flag_set[g]),
      .i_clear (flag_clr[g]),
      .o_flag  (flag_q[g])
    );
  end

  // Writable control registers; writes elsewhere are ignored
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      vbat_reg      <= RST_VBAT_SET;
      ichg_reg      <= RST_ICHG_SET;
      ctrl0_reg     <= RST_CTRL_FIRST;
      o_ctrl_second <= RST_CTRL_SECOND;
    end else if (wr_fire) begin
      unique case (ptr_reg)
        OFS_VBAT_SET:    vbat_reg      <= shift_in_reg;
        OFS_ICHG_SET:    ichg_reg      <= shift_in_reg;
        OFS_CTRL_FIRST:  ctrl0_reg     <= shift_in_reg;
        OFS_CTRL_SECOND: o_ctrl_second <= shift_in_reg;
        default:         ;
      endcase
    end
  end

  // Read multiplexer; unmapped offsets return zero
  always_comb begin
    rd_data = 8'h00;
    unique case (ptr_reg)
      OFS_FAULT_STATUS: begin
        rd_data                 = status_live_reg;
        rd_data[BIT_TMR_FLAG]   = flag_q[FC_TMR];
        rd_data[BIT_FIRST_WAKE] = flag_q[FC_WAKE1];
        rd_data[BIT_LATER_WAKE] = flag_q[FC_WAKE2];
      end
      OFS_EVENT_FLAGS: rd_data = flag_q[EV_THERM_FAULT:EV_BAT_OCP];
      OFS_VBAT_SET:    rd_data = vbat_reg;
      OFS_ICHG_SET:    rd_data = ichg_reg;
      OFS_CTRL_FIRST:  rd_data = ctrl0_reg;
      OFS_CTRL_SECOND: rd_data = o_ctrl_second;
      default:         rd_data = 8'h00;
    endcase
  end

  // Named control fields
  assign battery_voltage_code       = vbat_reg[6:0];
  assign fast_charge_code           = ichg_reg[6:0];
  assign precharge_ratio_select     = ctrl0_reg[BIT_PRE_SEL];
  assign termination_select         = ctrl0_reg[BIT_TERM_LO+1:BIT_TERM_LO];
  assign input_voltage_floor_select = ctrl0_reg[BIT_VFLR_LO+1:BIT_VFLR_LO];
  assign thermal_threshold_select   = ctrl0_reg[BIT_THERM_LO+1:BIT_THERM_LO];

  // Termination percentage, zero when termination is off
  always_comb begin
    unique case (termination_select)
      2'h0: term_pct = 5'h00;
      2'h1: term_pct = TERM_PCT_LO;
      2'h2: term_pct = TERM_PCT_MID;
      2'h3: term_pct = TERM_PCT_HI;
    endcase
  end

  // Analog set points; codes past 4650 mV are clamped to protect the cell
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_charging_off       <= 1'b0;
      o_battery_voltage_mv <= VBAT_BASE_MV;
      o_fast_charge_ma     <= ICHG_LOW_OFS;
      o_termination_pct    <= 5'h00;
      o_precharge_pct      <= 6'h00;
      o_input_floor_mv     <= 13'h0000;
      o_thermal_limit_c    <= 7'h00;
    end else begin
      o_charging_off <= ichg_reg[BIT_CHG_OFF];
      o_battery_voltage_mv <= VBAT_BASE_MV + VBAT_STEP_MV * 13'((battery_voltage_code >
                              VBAT_CODE_MAX) ? VBAT_CODE_MAX : battery_voltage_code);
      o_fast_charge_ma <= (fast_charge_code <= ICHG_LOW_MAX) ?
                          11'(fast_charge_code) + ICHG_LOW_OFS :
                          ICHG_HI_BASE + ICHG_STEP_MA * 11'(fast_charge_code - ICHG_HI_CODE);
      o_termination_pct <= term_pct;
      o_precharge_pct <= precharge_ratio_select ? 6'(term_pct) : {term_pct, 1'b0};
      unique case (input_voltage_floor_select)
        2'h0: o_input_floor_mv <= VFLR_LO_MV;
        2'h1: o_input_floor_mv <= VFLR_MID_MV;
        2'h2: o_input_floor_mv <= VFLR_HI_MV;
        2'h3: o_input_floor_mv <= 13'h0000;
      endcase
      o_thermal_limit_c <= (thermal_threshold_select == SEL_OFF) ? 7'h00 : THERM_LIM_C;
    end
  end

  // Checks on the register bank behaviour
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_ovp_live;
    i_input_overvoltage ##1 !i_input_overvoltage |=> !status_live_reg[BIT_OVP_LIVE];
  endproperty
  a_ovp_live: assert property (p_ovp_live) else $error("overvoltage live bit stuck");

  property p_lockout_live;
    i_battery_lockout |=> status_live_reg[BIT_BUVLO_LIVE] && flag_q[EV_BUVLO];
  endproperty
  a_lockout_live: assert property (p_lockout_live) else $error("lockout not shown");

  property p_zone;
    $stable(i_thermistor_zone) [*2] |-> status_live_reg[4:3] == i_thermistor_zone;
  endproperty
  a_zone: assert property (p_zone) else $error("zone field wrong");

  property p_tmr_hold;
    flag_q[FC_TMR] && !tmr_arm_reg && !(i_charge_enable ^ en_prev_reg) |=> flag_q[FC_TMR];
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("timer flag cleared early");

  property p_wake1;
    i_first_wake |=> flag_q[FC_WAKE1];
  endproperty
  a_wake1: assert property (p_wake1) else $error("wake flag not set");

  property p_therm_fault;
    i_thermistor_fault |=> flag_q[EV_THERM_FAULT] ##0 rd_data[7] || ptr_reg != OFS_EVENT_FLAGS;
  endproperty
  a_therm_fault: assert property (p_therm_fault) else $error("thermistor flag lost");

  property p_ocp;
    i_battery_overcurrent |=> flag_q[EV_BAT_OCP];
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent flag lost");

  property p_chg_off;
    ichg_reg[BIT_CHG_OFF] [*2] |-> o_charging_off;
  endproperty
  a_chg_off: assert property (p_chg_off) else $error("charging not disabled");

  property p_vbat;
    vbat_reg[6:0] <= VBAT_CODE_MAX |=>
      o_battery_voltage_mv == VBAT_BASE_MV + VBAT_STEP_MV * 13'($past(vbat_reg[6:0]));
  endproperty
  a_vbat: assert property (p_vbat) else $error("voltage set point wrong");

  property p_ichg;
    ichg_reg[6:0] <= ICHG_LOW_MAX |=>
      o_fast_charge_ma == 11'($past(ichg_reg[6:0])) + ICHG_LOW_OFS;
  endproperty
  a_ichg: assert property (p_ichg) else $error("current set point wrong");

  property p_rd_clear;
    rd_fire && ptr_reg == OFS_EVENT_FLAGS && !i_thermal_regulation |=> !flag_q[EV_HEAT_LIM];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flag survived read");

  c_write: cover property (wr_fire && ptr_reg == OFS_CTRL_FIRST);
  c_read_flags: cover property (rd_fire && ptr_reg == OFS_EVENT_FLAGS && flag_q[EV_OVP]);
  c_read_nack: cover property (state_reg == ST_RACK && scl_fall && nack_reg);
endmodule
`default_nettype wire

// file: dv/i2c_host_model.sv
// Behavioural serial bus controller standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h2A // Arbitrary target address
) (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Whole cycles; every phase lasts at least two clocks
  task automatic w(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // One bit, scl low on entry; data only moves while scl is low
  task automatic bt(input logic b, output logic s);
    o_sda_low = !b;
    w(4);
    o_scl = 1'b1;
    w(3);
    s = i_sda;
    w(3);
    o_scl = 1'b0;
    w(2);
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bt(d[i], s);
    bt(1'b1, s);
    ack = !s;
  endtask
  // Last byte is refused so the target lets go of the line
  task automatic rb(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
    bt(1'b1, s);
  endtask
  // Start from idle, or repeated start when scl is low
  task automatic sta();
    if (!o_scl) begin
      o_sda_low = 1'b0;
      w(4);
      o_scl = 1'b1;
      w(4);
    end
    o_sda_low = 1'b1;
    w(4);
    o_scl = 1'b0;
    w(2);
  endtask
  task automatic sto();
    o_sda_low = 1'b1;
    w(4);
    o_scl = 1'b1;
    w(4);
    o_sda_low = 1'b0;
    w(8);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic ok);
    logic k0, k1, k2;
    sta();
    wb({a, 1'b0}, k0);
    wb(p, k1);
    wb(d, k2);
    sto();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic k;
    sta();
    wb({ADDR, 1'b0}, k);
    wb(p, k);
    sta();
    wb({ADDR, 1'b1}, k);
    rb(d);
    sto();
  endtask
endmodule
`default_nettype wire

// file: dv/test_charger_status_and_control_regs.sv
// Self-checking bench for the charger register bank
`timescale 1ns/1ps
`default_nettype none
module test_charger_status_and_control_regs;
  import chg_regs_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A; // Arbitrary target address
  logic        i_mclk, i_rst, scl, sda_low, oe_n, sda, ovp, lock, tmr, en, wk1, wk2, off, ok;
  logic        sda_out;
  logic [1:0]  zone;
  logic [7:0]  ev, rdv, ctl2, em;
  logic [12:0] vmv, fmv;
  logic [10:0] ima;
  logic [4:0]  term;
  logic [5:0]  pre;
  logic [6:0]  thc;
  logic [7:0]  mr [3:6] = '{8'h46, 8'h05, 8'h2C, 8'h56};
  logic [31:0] rs = 32'd97264;
  int          tp[4] = '{0, 5, 10, 20};
  int          fl[4] = '{4200, 4500, 4700, 0};
  int          err_total, checks_done, cyc;
  // Open-drain data line with pull-up
  assign sda = !(sda_low | (!oe_n & !sda_out));
  i2c_host_model #(.ADDR(ADDR)) host (.i_mclk, .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  charger_status_and_control_regs #(.DEV_ADDR(ADDR)) dut (
    .i_mclk, .i_rst, .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe_n(oe_n),
    .i_input_overvoltage(ovp | ev[2]), .i_battery_lockout(lock | ev[1]),
    .i_thermistor_zone(zone),
    .i_charge_timer_expired(tmr), .i_charge_enable(en), .i_first_wake(wk1),
    .i_second_wake(wk2), .i_thermistor_fault(ev[7]), .i_input_current_limit(ev[6]),
    .i_power_path_regulation(ev[5]), .i_input_voltage_regulation(ev[4]),
    .i_thermal_regulation(ev[3]), .i_battery_overcurrent(ev[0]), .o_charging_off(off),
    .o_battery_voltage_mv(vmv), .o_fast_charge_ma(ima), .o_termination_pct(term),
    .o_precharge_pct(pre), .o_input_floor_mv(fmv), .o_thermal_limit_c(thc),
    .o_ctrl_second(ctl2));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic ck(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] p, input logic [7:0] e, input string n);
    host.rd(p, rdv);
    ck(n, e, rdv);
  endtask
  // Set points expected from the model register copy
  task automatic outs();
    logic [6:0] v, c;
    int t;
    v = mr[3][6:0];
    c = mr[4][6:0];
    t = tp[mr[5][5:4]];
    ck("volt", 3500 + 10 * (v > 115 ? 115 : v), vmv);
    ck("ichg", c <= 30 ? c + 5 : 40 + (c - 31) * 10, ima);
    ck("term", t, term);
    ck("pre", mr[5][6] ? t : 2 * t, pre);
    ck("floor", fl[mr[5][3:2]], fmv);
    ck("therm", mr[5][1:0] == 2'h3 ? 0 : 100, thc);
    ck("off", mr[4][7], off);
    ck("ctl2", mr[6], ctl2);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // Hang guard, far above the expected run
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    {i_rst, en} = 2'b11;
    {ovp, lock, zone, tmr, wk1, wk2, ev} = '0;
    host.w(2);
    i_rst = 1'b0;
    host.w(2);
    for (int r = 3; r <= 6; r++) rc(8'(r), mr[r], "reset value");
    outs();
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      mr[3] = 8'(rnd() % 116);
      mr[4] = 8'(rnd());
      mr[5] = 8'(k * 21 + (k % 2) * 64);
      mr[6] = 8'(rnd());
      for (int r = 3; r <= 6; r++) host.wr(ADDR, 8'(r), mr[r], ok);
      outs();
      for (int r = 3; r <= 6; r++) rc(8'(r), mr[r], "setting");
    end
    $display("settings test done");
    em = '0;
    for (int k = 0; k < 4; k++) begin
      {ovp, lock, zone} = 4'(rnd());
      em[2:1] = em[2:1] | {ovp, lock};
      rc(OFS_FAULT_STATUS, {ovp, lock, 1'b0, zone, 3'b0}, "live status");
    end
    {ovp, lock, zone} = '0;
    rc(OFS_EVENT_FLAGS, em, "live events");
    $display("live status test done");
    for (int i = 0; i < 8; i++) begin
      ev = 8'h01 << i;
      host.w(2);
      ev = '0;
      rc(OFS_EVENT_FLAGS, 8'h01 << i, "event flag");
      rc(OFS_EVENT_FLAGS, 8'h00, "event cleared");
    end
    ev = 8'hFB;
    rc(OFS_EVENT_FLAGS, 8'hFB, "event held");
    ev = '0;
    rc(OFS_EVENT_FLAGS, 8'hFB, "event reset");
    $display("event test done");
    {tmr, wk1, wk2} = 3'b111;
    host.w(2);
    {tmr, wk1, wk2} = 3'b000;
    rc(OFS_FAULT_STATUS, 8'h07, "status flags");
    rc(OFS_FAULT_STATUS, 8'h04, "timer kept");
    en = 1'b0;
    host.w(2);
    en = 1'b1;
    rc(OFS_FAULT_STATUS, 8'h04, "timer after toggle");
    rc(OFS_FAULT_STATUS, 8'h00, "timer cleared");
    $display("status flag test done");
    host.wr(ADDR ^ 7'h01, OFS_VBAT_SET, 8'h00, ok);
    ck("foreign ack", 16'h0000, {15'h0, ok});
    rc(8'h07, 8'h00, "unmapped");
    $display("bus test done");
    end_of_test();
  end
endmodule
`default_nettype wire
